// ### bench/rcb_board.sv
// board tristate driver model of the reference clock b pin
`timescale 1ns/1ps
module rcb_board (
	input wire logic drv,
	input wire logic drv_oe_n,
	output wire pin
);
	assign pin = drv_oe_n ? 1'bz : drv;
endmodule : rcb_board

// ### bench/rcb_ref_clk_b_checker.sv
// checker for the reference clock b selector
`timescale 1ns/1ps
module rcb_ref_clk_b_checker (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic [28:0] rx_rec_clk,
	input wire logic ext_clk_in_b,
	input wire logic ext_clk_b_rate_sel,
	input wire logic ref_clock_out_b,
	input wire logic ref_clock_out_b_oe_n,
	input wire logic [4:0] ref_out_b_active_source
);
	wire hit = psel && penable && paddr == 12'h0280;
	wire wr = hit && pwrite;
	wire [4:0] a = ref_out_b_active_source;
	wire s = a > 5'h1c ? ext_clk_in_b : rx_rec_clk[a];
	wire o = ref_clock_out_b;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	AST_OE: assert property (wr |-> ##2 ref_clock_out_b_oe_n == !$past(pwdata[6], 2))
		else $error("oe mismatch");
	AST_RATE: assert property (wr |-> ##2 ext_clk_b_rate_sel == $past(pwdata[5], 2))
		else $error("rate mismatch");
	AST_RD: assert property (hit && !pwrite |-> prdata[6:5] == {!ref_clock_out_b_oe_n, ext_clk_b_rate_sel})
		else $error("readback mismatch");
	AST_RST: assert property ($rose(rstn) |-> !ref_clock_out_b_oe_n && !ext_clk_b_rate_sel && a == 5'h01)
		else $error("reset values wrong");
	AST_PASS: assert property (o |-> $past(s) || $past(s, 2))
		else $error("output high without source");
	AST_FOLLOW: assert property (($stable(a) && !psel)[*8] ##0 s[*2] |=> o)
		else $error("output not following source");
	AST_RUNT: assert property (!$stable(o) |=> $stable(o))
		else $error("runt pulse");
	AST_DROP: assert property (!$stable(a) |-> !o && !$past(o))
		else $error("switch while output high");
endmodule : rcb_ref_clk_b_checker
bind rcb_ref_clk_b rcb_ref_clk_b_checker chk (.*);

// ### bench/tb.sv
// testbench for the reference clock b selector
`timescale 1ns/1ps
module tb;
	logic mclk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, ext = 0, rdy, rate, o, oe_n;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [28:0] rx = '0;
	logic [4:0] act;
	wire pin;
	int n_mismatch = 0, tests_run = 0, cyc = 0;
	rcb_ref_clk_b dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(rdy),
		.pslverr(), .rx_rec_clk(rx), .ext_clk_in_b(ext), .ext_clk_b_rate_sel(rate),
		.ref_clock_out_b(o), .ref_clock_out_b_oe_n(oe_n), .ref_out_b_active_source(act));
	rcb_board brd (.drv(o), .drv_oe_n(oe_n), .pin(pin));
	initial forever #10 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		rx <= {29{cyc[1]}} ^ 29'h0aaa_aaaa;
		ext <= cyc[2];
		if (cyc == 3000) begin
			n_mismatch++;
			print_verdict;
		end
	end
	task automatic chk(input string nm, input logic [31:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		do @(posedge mclk); while (rdy !== 1'b1);
		rd = prdata;
		psel <= 0;
		penable <= 0;
		@(posedge mclk);
	endtask : apb
	task automatic t_reset;
		apb(0, 12'h0280, 0);
		chk("cfg", rd, 32'h0000_0041);
	endtask : t_reset
	task automatic t_cfg;
		apb(1, 12'h0280, 32'h0000_00bd);
		apb(0, 12'h0280, 0);
		chk("readback", rd, 32'h0000_003d);
		apb(0, 12'h0284, 0);
		chk("unmapped", rd, 32'h0000_0000);
		chk("pin", pin, 1'bz);
		chk("rate", rate, 1);
	endtask : t_cfg
	task automatic t_src;
		logic exp_clk;
		for (int s = 0; s < 32; s++) begin
			apb(1, 12'h0280, 32'h0000_0040 | s);
			for (int k = 0; k < 20 && act !== s[4:0]; k++) @(posedge mclk);
			chk("src", act, s);
			chk("rate", rate, 0);
			chk("oe", oe_n, 0);
			repeat (6) @(posedge mclk);
			@(negedge mclk);
			exp_clk = (s > rcb_pkg::RCB_LAST_CH) ? ext : rx[s];
			repeat (8) begin
				@(negedge mclk);
				chk("route", o, exp_clk);
				chk("pin", pin, exp_clk);
				exp_clk = (s > rcb_pkg::RCB_LAST_CH) ? ext : rx[s];
			end
			@(posedge mclk);
		end
	endtask : t_src
	task automatic print_verdict;
		if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (3) @(posedge mclk);
		rstn <= 1;
		@(posedge mclk);
		t_reset;
		t_cfg;
		t_src;
		print_verdict;
	end
endmodule : tb

// ### src/rcb_pkg.sv
// package for the reference clock output b selector
package rcb_pkg;
	localparam logic [11:0] RCB_REF_B_SEL_OFFSET = 12'h0280;
	localparam logic [7:0] RCB_REF_B_SEL_RESET = 8'h41;
	localparam int RCB_SRC_LSB = 0;
	localparam int RCB_SRC_W = 5;
	localparam int RCB_RATE_BIT = 5;
	localparam int RCB_EN_BIT = 6;
	localparam int RCB_NUM_CH = 29;
	localparam logic [4:0] RCB_LAST_CH = 5'h1c;
	localparam logic [31:0] RCB_UNMAPPED_RDATA = 32'h0000_0000;
	typedef enum logic [1:0] {RCB_SW_RUN, RCB_SW_DROP, RCB_SW_PICK} rcb_sw_e;
endpackage : rcb_pkg

// ### src/rcb_ref_clk_b.sv
// reference clock output b source selection with apb configuration register
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - with the enable bit at 0 the output pin floats, with it at 1 the pin is driven.
// - the enable bit resets to 1 so the output is driven by default.
// - the rate bit marks the external clock input as t1 rate at 0 and e1 rate at 1.
// - the rate bit resets to 0, meaning a t1 rate external clock.
// - source values 0 to 28 route the recovered clock of that channel to the output.
// - the source field resets to 1, selecting the recovered clock of channel 1.
// - source values 29 to 31 route the external clock input to the output.
module rcb_ref_clk_b (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [rcb_pkg::RCB_NUM_CH-1:0] rx_rec_clk,
	input wire logic ext_clk_in_b,
	output logic ext_clk_b_rate_sel,
	output logic ref_clock_out_b,
	output logic ref_clock_out_b_oe_n,
	output logic [4:0] ref_out_b_active_source
);
	import rcb_pkg::*;

	logic [7:0] cfg_r;
	logic [7:0] cfg_nxt;
	logic oe_n_r;
	logic oe_n_nxt;
	logic rate_r;
	logic rate_nxt;
	logic [31:0] prdata_nxt;
	logic [4:0] active_src_r;
	logic [4:0] active_src_nxt;
	logic ref_out_r;
	logic ref_out_nxt;
	rcb_sw_e sw_state_r;
	rcb_sw_e sw_state_nxt;
	logic sel_clk;
	logic sel_low;
	logic addr_hit;
	logic wr_en;
	logic rd_setup;
	logic [4:0] req_src;
	logic src_pending;
	logic start_switch;

	// field helpers
	function automatic logic src_is_ext(input logic [4:0] src);
		src_is_ext = (src > RCB_LAST_CH);
	endfunction : src_is_ext

	function automatic logic pick_clk(
		input logic [4:0] src,
		input logic [RCB_NUM_CH-1:0] ch,
		input logic ext
	);
		if (src_is_ext(src)) begin
			pick_clk = ext;
		end else begin
			pick_clk = ch[src];
		end
	endfunction : pick_clk

	function automatic logic [4:0] cfg_src(input logic [7:0] cfg);
		cfg_src = cfg[RCB_SRC_LSB +: RCB_SRC_W];
	endfunction : cfg_src

	function automatic logic cfg_bit(
		input logic [7:0] cfg,
		input int pos
	);
		cfg_bit = cfg[pos[2:0]];
	endfunction : cfg_bit

	function automatic logic [7:0] cfg_from_wdata(input logic [31:0] wdata);
		cfg_from_wdata = {1'b0, wdata[RCB_EN_BIT:0]};
	endfunction : cfg_from_wdata

	function automatic logic [31:0] cfg_word(input logic [7:0] cfg);
		cfg_word = {24'h00_0000, cfg};
	endfunction : cfg_word

	function automatic logic apb_setup(
		input logic sel,
		input logic en
	);
		apb_setup = sel && !en;
	endfunction : apb_setup

	function automatic logic apb_access(
		input logic sel,
		input logic en
	);
		apb_access = sel && en;
	endfunction : apb_access

	// apb decode, zero wait states
	assign addr_hit = (paddr == RCB_REF_B_SEL_OFFSET);
	assign wr_en = apb_access(psel, penable) && pwrite && addr_hit;
	assign rd_setup = apb_setup(psel, penable) && !pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;

	// configuration register write, reserved bit 7 kept at zero
	always_comb begin
		cfg_nxt = cfg_r;
		if (wr_en) begin
			cfg_nxt = cfg_from_wdata(pwdata);
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			cfg_r <= RCB_REF_B_SEL_RESET;
		end else begin
			cfg_r <= cfg_nxt;
		end
	end

	// output enable and rate flops, updated at the write edge
	assign oe_n_nxt = ~cfg_bit(cfg_nxt, RCB_EN_BIT);
	assign rate_nxt = cfg_bit(cfg_nxt, RCB_RATE_BIT);

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			oe_n_r <= ~RCB_REF_B_SEL_RESET[RCB_EN_BIT];
		end else begin
			oe_n_r <= oe_n_nxt;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			rate_r <= RCB_REF_B_SEL_RESET[RCB_RATE_BIT];
		end else begin
			rate_r <= rate_nxt;
		end
	end

	// read data, loaded in the setup phase
	always_comb begin
		prdata_nxt = prdata;
		if (rd_setup) begin
			if (addr_hit) begin
				prdata_nxt = cfg_word(cfg_r);
			end else begin
				prdata_nxt = RCB_UNMAPPED_RDATA;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			prdata <= RCB_UNMAPPED_RDATA;
		end else begin
			prdata <= prdata_nxt;
		end
	end

	// glitch-free switch: wait for current clock low, hold low, pick new source while it is low
	assign req_src = cfg_src(cfg_r);
	assign src_pending = (req_src != active_src_r);
	assign sel_clk = pick_clk(active_src_r, rx_rec_clk, ext_clk_in_b);
	assign sel_low = !sel_clk;
	assign start_switch = src_pending && sel_low;

	always_comb begin
		sw_state_nxt = sw_state_r;
		active_src_nxt = active_src_r;
		ref_out_nxt = ref_out_r;
		unique case (sw_state_r)
			RCB_SW_RUN: begin
				ref_out_nxt = sel_clk;
				if (start_switch) begin
					sw_state_nxt = RCB_SW_DROP;
				end
			end
			RCB_SW_DROP: begin
				ref_out_nxt = 1'b0;
				active_src_nxt = req_src;
				sw_state_nxt = RCB_SW_PICK;
			end
			RCB_SW_PICK: begin
				ref_out_nxt = 1'b0;
				if (sel_low) begin
					sw_state_nxt = RCB_SW_RUN;
				end
			end
		endcase
	end

	// switch state, active source and output registers
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			sw_state_r <= RCB_SW_RUN;
		end else begin
			sw_state_r <= sw_state_nxt;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			active_src_r <= RCB_REF_B_SEL_RESET[4:0];
		end else begin
			active_src_r <= active_src_nxt;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			ref_out_r <= 1'b0;
		end else begin
			ref_out_r <= ref_out_nxt;
		end
	end

	// pins
	assign ref_clock_out_b = ref_out_r;
	assign ref_clock_out_b_oe_n = oe_n_r;
	assign ext_clk_b_rate_sel = rate_r;
	assign ref_out_b_active_source = active_src_r;
endmodule : rcb_ref_clk_b
